//--- logic/serial_flash_protect_hold.v
`include "sfp_defs.vh"
`default_nettype none
module serial_flash_protect_hold #(
    parameter ADDR_W     = `SFP_ADDR_W,
    parameter SECT_W     = `SFP_SECT_W,
    parameter FIFO_DEPTH = `SFP_FIFO_DEPTH,
    parameter STAT_CYC   = `SFP_STATUS_UPDATE_CYC
) (
    // clock and reset
    input  wire mclk_i,
    input  wire rst_n_i,
    // serial pins
    input  wire sck_i,
    input  wire cs_n_i,
    input  wire si_i,
    input  wire hold_n_i,
    input  wire wp_n_i,
    output reg  so_o,
    output reg  so_oe_o,
    // power and activity
    output reg  active_o,
    output reg  deep_sleep_o,
    output reg  busy_o
);
    localparam SN = ADDR_W - SECT_W;
    localparam [3:0] S_IDLE  = 4'h1;
    localparam [3:0] S_PROG  = 4'h2;
    localparam [3:0] S_ERASE = 4'h4;
    localparam [3:0] S_STAT  = 4'h8;
    localparam [1:0] O_NONE  = 2'h0;
    localparam [1:0] O_STAT  = 2'h1;
    localparam [1:0] O_DATA  = 2'h2;

    function guarded;
        input [2:0]    lvl;
        input [SN-1:0] sect;
        reg   [SN:0]   lim;
        begin
            lim     = ({{SN{1'b0}}, 1'b1} << SN) - ({{SN{1'b0}}, 1'b1} << lvl);
            guarded = (lvl == 3'h7) ||
                      ((lvl != 3'h0) && ((lvl >= SN) || ({1'b0, sect} >= lim)));
        end
    endfunction

    // pin synchronisers {wp, hold, cs, si, sck}
    reg  [4:0] meta_reg;
    reg  [4:0] sync_reg;
    reg  [4:0] prev_reg;
    wire sck_s  = sync_reg[0];
    wire si_s   = sync_reg[1];
    wire cs_s   = sync_reg[2];
    wire hold_s = sync_reg[3];
    wire wp_s   = sync_reg[4];
    wire sck_rise  = sck_s & ~prev_reg[0];
    wire sck_fall  = ~sck_s & prev_reg[0];
    wire cs_fall   = ~cs_s & prev_reg[2];
    wire cs_rise   = cs_s & ~prev_reg[2];
    wire hold_fall = ~hold_s & prev_reg[3];
    wire hold_rise = hold_s & ~prev_reg[3];

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            meta_reg <= 5'h1c;
            sync_reg <= 5'h1c;
            prev_reg <= 5'h1c;
        end else begin
            meta_reg <= {wp_n_i, hold_n_i, cs_n_i, si_i, sck_i};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // pause tracking
    reg hold_reg;
    reg hold_start_reg;
    reg hold_end_reg;

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hold_reg       <= 1'b0;
            hold_start_reg <= 1'b0;
            hold_end_reg   <= 1'b0;
        end else if (cs_s) begin
            hold_reg       <= 1'b0;
            hold_start_reg <= 1'b0;
            hold_end_reg   <= 1'b0;
        end else if (hold_fall) begin
            hold_end_reg <= 1'b0;
            if (!sck_s)
                hold_reg <= 1'b1;
            else
                hold_start_reg <= 1'b1;
        end else if (hold_rise) begin
            hold_start_reg <= 1'b0;
            if (!sck_s)
                hold_reg <= 1'b0;
            else if (hold_reg)
                hold_end_reg <= 1'b1;
        end else if (sck_fall) begin
            if (hold_start_reg) begin
                hold_reg       <= 1'b1;
                hold_start_reg <= 1'b0;
            end
            if (hold_end_reg) begin
                hold_reg     <= 1'b0;
                hold_end_reg <= 1'b0;
            end
        end
    end

    // processor state shared with the serial side
    reg  [3:0] st_reg;
    reg        arm_reg;
    reg  [2:0] guard_reg;
    reg        lock_reg;
    reg        sleep_reg;
    wire       busy_w   = ~st_reg[0];
    wire [7:0] status_w = {lock_reg, 2'b00, guard_reg, arm_reg, busy_w};

    reg  [7:0] mem  [0:(1<<ADDR_W)-1];
    reg  [7:0] pbuf [0:`SFP_PAGE_BYTES-1];

    // serial shifter
    reg  [7:0]        in_sr_reg;
    reg  [2:0]        bit_cnt_reg;
    reg  [2:0]        nbytes_reg;
    reg  [7:0]        cmd_reg;
    reg  [23:0]       addr_reg;
    reg  [1:0]        out_mode_reg;
    reg  [2:0]        obit_reg;
    reg  [ADDR_W-1:0] rd_addr_reg;
    reg  [7:0]        rd_q_reg;
    reg               bad_reg;
    reg               skip_reg;
    reg               push_v_reg;
    reg  [9:0]        push_d_reg;
    reg               end_pend_reg;
    reg  [1:0]        end_kind_reg;
    wire              fifo_in_ready;
    wire [7:0]        new_byte = {in_sr_reg[6:0], si_s};
    wire [23:0]       full_addr = {addr_reg[15:0], new_byte};
    wire              skip_now = (nbytes_reg == 3'h0) ? busy_w : skip_reg;

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            in_sr_reg    <= 8'h00;
            bit_cnt_reg  <= 3'h0;
            nbytes_reg   <= 3'h0;
            cmd_reg      <= 8'h00;
            addr_reg     <= 24'h000000;
            out_mode_reg <= O_NONE;
            obit_reg     <= 3'h0;
            rd_addr_reg  <= {ADDR_W{1'b0}};
            rd_q_reg     <= 8'h00;
            bad_reg      <= 1'b0;
            skip_reg     <= 1'b0;
            push_v_reg   <= 1'b0;
            push_d_reg   <= 10'h000;
            end_pend_reg <= 1'b0;
            end_kind_reg <= `SFP_K_END_BAD;
            so_o         <= 1'b0;
        end else begin
            push_v_reg <= 1'b0;
            rd_q_reg   <= mem[rd_addr_reg];
            if (push_v_reg && !fifo_in_ready)
                bad_reg <= 1'b1;
            if (end_pend_reg && fifo_in_ready && !push_v_reg) begin
                push_v_reg   <= 1'b1;
                push_d_reg   <= {end_kind_reg, 8'h00};
                end_pend_reg <= 1'b0;
            end
            if (cs_fall) begin
                bit_cnt_reg  <= 3'h0;
                nbytes_reg   <= 3'h0;
                bad_reg      <= push_v_reg & ~fifo_in_ready;
                skip_reg     <= 1'b0;
                out_mode_reg <= O_NONE;
                obit_reg     <= 3'h0;
            end else if (cs_rise) begin
                out_mode_reg <= O_NONE;
                if (!skip_reg && (nbytes_reg != 3'h0 || bit_cnt_reg != 3'h0)) begin
                    end_pend_reg <= 1'b1;
                    if (bit_cnt_reg == 3'h0 && !bad_reg && !hold_reg)
                        end_kind_reg <= `SFP_K_END_OK;
                    else
                        end_kind_reg <= `SFP_K_END_BAD;
                end
            end else if (sck_rise && !cs_s && !hold_reg) begin
                in_sr_reg   <= new_byte;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    if (nbytes_reg != 3'h4)
                        nbytes_reg <= nbytes_reg + 3'h1;
                    if (nbytes_reg == 3'h0) begin
                        cmd_reg  <= new_byte;
                        skip_reg <= busy_w;
                        if (new_byte == `SFP_CMD_READ_STATUS)
                            out_mode_reg <= O_STAT;
                    end else if (nbytes_reg != 3'h4) begin
                        addr_reg <= full_addr;
                    end
                    if (nbytes_reg == 3'h3 && cmd_reg == `SFP_CMD_READ_DATA && !skip_reg) begin
                        out_mode_reg <= O_DATA;
                        rd_addr_reg  <= full_addr[ADDR_W-1:0];
                    end
                    if (!skip_now) begin
                        push_v_reg <= 1'b1;
                        push_d_reg <= {(nbytes_reg == 3'h0) ? `SFP_K_CMD : `SFP_K_DATA,
                                       new_byte};
                    end
                end
            end else if (sck_fall && !cs_s && !hold_reg && out_mode_reg != O_NONE) begin
                obit_reg <= obit_reg + 3'h1;
                if (out_mode_reg == O_STAT)
                    so_o <= status_w[3'h7 - obit_reg];
                else
                    so_o <= rd_q_reg[3'h7 - obit_reg];
                if (out_mode_reg == O_DATA && obit_reg == 3'h7)
                    rd_addr_reg <= rd_addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // command fifo between the serial side and the processor
    wire       f_valid;
    wire [9:0] f_data;
    wire       pop = f_valid & st_reg[0];

    sfp_byte_fifo #(
        .W     (10),
        .DEPTH (FIFO_DEPTH),
        .AW    ($clog2(FIFO_DEPTH))
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push_v_reg),
        .in_data_i   (push_d_reg),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (f_valid),
        .out_data_o  (f_data),
        .out_ready_i (st_reg[0])
    );

    // command processor
    reg  [7:0]        pcmd_reg;
    reg  [2:0]        pidx_reg;
    reg  [23:0]       paddr_reg;
    reg  [8:0]        pcnt_reg;
    reg  [7:0]        wcol_reg;
    reg  [7:0]        pdata_reg;
    reg  [8:0]        wi_reg;
    reg  [ADDR_W-1:0] ea_reg;
    reg               full_reg;
    reg  [15:0]       tmr_reg;
    wire [1:0]        f_kind   = f_data[9:8];
    wire [7:0]        f_byte   = f_data[7:0];
    wire              hard_w   = lock_reg & ~wp_s;
    wire [SN-1:0]     psect    = paddr_reg[ADDR_W-1:SECT_W];
    wire              modify_ok = arm_reg & ~sleep_reg;
    wire [7:0]        pcol     = paddr_reg[7:0] + wi_reg[7:0];
    wire [ADDR_W-1:0] pa       = {paddr_reg[ADDR_W-1:8], pcol};
    wire              ea_last  = full_reg ? (&ea_reg) : (&ea_reg[SECT_W-1:0]);

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_reg    <= S_IDLE;
            arm_reg   <= 1'b0;
            guard_reg <= `SFP_NV_RST;
            lock_reg  <= 1'b0;
            sleep_reg <= 1'b0;
            pcmd_reg  <= 8'h00;
            pidx_reg  <= 3'h0;
            paddr_reg <= 24'h000000;
            pcnt_reg  <= 9'h000;
            wcol_reg  <= 8'h00;
            pdata_reg <= 8'h00;
            wi_reg    <= 9'h000;
            ea_reg    <= {ADDR_W{1'b0}};
            full_reg  <= 1'b0;
            tmr_reg   <= 16'h0000;
        end else begin
            case (st_reg)
            S_IDLE: begin
                if (pop) begin
                    case (f_kind)
                    `SFP_K_CMD: begin
                        pcmd_reg <= f_byte;
                        pidx_reg <= 3'h1;
                        pcnt_reg <= 9'h000;
                    end
                    `SFP_K_DATA: begin
                        if (pidx_reg != 3'h4)
                            pidx_reg <= pidx_reg + 3'h1;
                        if (pidx_reg == 3'h1)
                            pdata_reg <= f_byte;
                        if (pidx_reg != 3'h4) begin
                            paddr_reg <= {paddr_reg[15:0], f_byte};
                            wcol_reg  <= f_byte;
                        end else if (pcmd_reg == `SFP_CMD_PAGE_PROGRAM) begin
                            pbuf[wcol_reg] <= f_byte;
                            wcol_reg       <= wcol_reg + 8'h01;
                            if (pcnt_reg != 9'h100)
                                pcnt_reg <= pcnt_reg + 9'h001;
                        end
                    end
                    `SFP_K_END_OK: begin
                        pcmd_reg <= 8'h00;
                        wi_reg   <= 9'h000;
                        case (pcmd_reg)
                        `SFP_CMD_ARM_WRITE:    arm_reg   <= 1'b1;
                        `SFP_CMD_DISARM_WRITE: arm_reg   <= 1'b0;
                        `SFP_CMD_SLEEP_DEEP:   sleep_reg <= 1'b1;
                        `SFP_CMD_WAKE:         sleep_reg <= 1'b0;
                        `SFP_CMD_PAGE_PROGRAM: begin
                            if (modify_ok && pidx_reg == 3'h4 && pcnt_reg != 9'h000 &&
                                !guarded(guard_reg, psect)) begin
                                if (pcnt_reg == 9'h100)
                                    paddr_reg[7:0] <= 8'h00;
                                st_reg <= S_PROG;
                            end
                        end
                        `SFP_CMD_REGION_CLEAR: begin
                            if (modify_ok && pidx_reg == 3'h4 &&
                                !guarded(guard_reg, psect)) begin
                                ea_reg   <= {psect, {SECT_W{1'b0}}};
                                full_reg <= 1'b0;
                                st_reg   <= S_ERASE;
                            end
                        end
                        `SFP_CMD_FULL_CLEAR: begin
                            if (modify_ok && pidx_reg == 3'h1 && guard_reg == 3'h0) begin
                                ea_reg   <= {ADDR_W{1'b0}};
                                full_reg <= 1'b1;
                                st_reg   <= S_ERASE;
                            end
                        end
                        `SFP_CMD_STATUS_UPDATE: begin
                            if (arm_reg && pidx_reg >= 3'h2 && !hard_w) begin
                                tmr_reg <= STAT_CYC[15:0] - 16'h0001;
                                st_reg  <= S_STAT;
                            end
                        end
                        default: pcmd_reg <= 8'h00;
                        endcase
                    end
                    default: pcmd_reg <= 8'h00;
                    endcase
                end
            end
            S_PROG: begin
                mem[pa] <= mem[pa] & pbuf[pcol];
                wi_reg  <= wi_reg + 9'h001;
                if (wi_reg == pcnt_reg - 9'h001) begin
                    arm_reg <= 1'b0;
                    st_reg  <= S_IDLE;
                end
            end
            S_ERASE: begin
                mem[ea_reg] <= 8'hff;
                ea_reg      <= ea_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
                if (ea_last) begin
                    arm_reg <= 1'b0;
                    st_reg  <= S_IDLE;
                end
            end
            S_STAT: begin
                tmr_reg <= tmr_reg - 16'h0001;
                if (tmr_reg == 16'h0000) begin
                    guard_reg <= pdata_reg[`SFP_ST_GUARD_HI:`SFP_ST_GUARD_LO];
                    lock_reg  <= pdata_reg[`SFP_ST_LOCK];
                    arm_reg   <= 1'b0;
                    st_reg    <= S_IDLE;
                end
            end
            default: st_reg <= S_IDLE;
            endcase
        end
    end

    // registered pin and power outputs
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            so_oe_o      <= 1'b0;
            active_o     <= 1'b0;
            deep_sleep_o <= 1'b0;
            busy_o       <= 1'b0;
        end else begin
            so_oe_o      <= ~cs_s & ~hold_reg & (out_mode_reg != O_NONE);
            active_o     <= ~cs_s | busy_w;
            deep_sleep_o <= sleep_reg & cs_s & ~busy_w;
            busy_o       <= busy_w;
        end
    end
endmodule
`default_nettype wire

//--- logic/sfp_defs.vh
// Functional notes
// - works with clock modes 0 and 3
// - sample input on rise, drive output on fall
// - all transfers are whole eight-bit bytes
// - page program takes 1 to 256 bytes
// - programming only clears bits; erase sets them
// - region clear sector, full clear whole array
// - busy flag in status while operation runs
// - active while selected or operation still running
// - after deep sleep, ignore program and erase
// - arm command sets the write-arm latch
// - latch cleared at reset and after modifying commands
// - guard level bits protect top sectors
// - lock bit plus low protect pin freezes guards
// - execute only on whole multiple of eight clocks
// - pause never aborts a running operation
// - pause start on pause fall or clock fall
// - pause end on pause rise or clock fall
// - during pause output floats, inputs ignored
// - chip select rise during pause resets interface
// - deselected means output floats
// - msb first, one-byte command codes
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH

`define SFP_CMD_ARM_WRITE     8'h06
`define SFP_CMD_DISARM_WRITE  8'h04
`define SFP_CMD_READ_STATUS   8'h05
`define SFP_CMD_STATUS_UPDATE 8'h01
`define SFP_CMD_READ_DATA     8'h03
`define SFP_CMD_PAGE_PROGRAM  8'h02
`define SFP_CMD_REGION_CLEAR  8'hd8
`define SFP_CMD_FULL_CLEAR    8'hc7
`define SFP_CMD_SLEEP_DEEP    8'hb9
`define SFP_CMD_WAKE          8'hab

`define SFP_ST_BUSY     0
`define SFP_ST_ARM      1
`define SFP_ST_GUARD_LO 2
`define SFP_ST_GUARD_HI 4
`define SFP_ST_LOCK     7
`define SFP_NV_RST      3'h0

`define SFP_K_DATA    2'h0
`define SFP_K_CMD     2'h1
`define SFP_K_END_OK  2'h2
`define SFP_K_END_BAD 2'h3

`define SFP_ADDR_W     23
`define SFP_SECT_W     16
`define SFP_PAGE_BYTES 256
`define SFP_FIFO_DEPTH 16

`define SFP_CLK_NS           10
`define SFP_STATUS_UPDATE_NS 160
`define SFP_STATUS_UPDATE_CYC ((`SFP_STATUS_UPDATE_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)

`endif

//--- logic/sfp_byte_fifo.v
`default_nettype none
module sfp_byte_fifo #(
    parameter W     = 10,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire         mclk_i,
    input  wire         rst_n_i,
    // fill side
    input  wire         in_valid_i,
    input  wire [W-1:0] in_data_i,
    output wire         in_ready_o,
    // drain side
    output wire         out_valid_o,
    output wire [W-1:0] out_data_o,
    input  wire         out_ready_i
);
    reg  [W-1:0] store [0:DEPTH-1];
    reg  [AW:0]  wr_reg;
    reg  [AW:0]  rd_reg;
    wire [AW:0]  fill = wr_reg - rd_reg;
    wire         push = in_valid_i & in_ready_o;
    wire         pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (fill != DEPTH[AW:0]);
    assign out_valid_o = (fill != {(AW+1){1'b0}});
    assign out_data_o  = store[rd_reg[AW-1:0]];

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                store[wr_reg[AW-1:0]] <= in_data_i;
                wr_reg                <= wr_reg + 1'b1;
            end
            if (pop)
                rd_reg <= rd_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- verification/sfp_check_sva.sv
`default_nettype none
module sfp_check_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // serial pins
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    // power and activity
    input wire logic active_o,
    input wire logic deep_sleep_o,
    input wire logic busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_deselect_floats: assert property (cs_n_i [*5] |-> !so_oe_o)
        else $error("output driven while deselected");
    a_pause_floats: assert property ((!hold_n_i && !sck_i) [*5] |-> !so_oe_o)
        else $error("output driven while paused");
    a_busy_keeps_active: assert property (busy_o [*2] |-> active_o)
        else $error("standby while operation runs");
    a_standby_when_idle: assert property ((cs_n_i && !busy_o) [*8] |-> !active_o)
        else $error("active while deselected and idle");
    a_oe_after_select: assert property ($rose(so_oe_o) |-> !$past(cs_n_i, 4))
        else $error("output enabled without selection");
    a_so_on_fall: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o)
        |-> !$past(sck_i, 2))
        else $error("serial output moved outside a clock fall");
    a_busy_after_frame: assert property ($rose(busy_o) |-> $past(cs_n_i, 5))
        else $error("operation started inside a frame");
    a_sleep_quiet: assert property (deep_sleep_o |-> !busy_o && !so_oe_o)
        else $error("activity during deep sleep");

    c_busy: cover property ($rose(busy_o));
    c_read: cover property ($rose(so_oe_o));
    c_sleep: cover property ($rose(deep_sleep_o));
endmodule
`default_nettype wire

//--- verification/sfp_host_model.sv
`default_nettype none
module sfp_host_model (
    // clock
    input  wire logic mclk_i,
    // device answer
    input  wire logic so_i,
    input  wire logic so_oe_i,
    // host drive
    output var logic  sck_o,
    output var logic  cs_n_o,
    output var logic  si_o,
    output var logic  hold_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx [16];
    logic [7:0] rx [16];
    bit         mode3 = 1'b0;

    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
    end

    // half of the 80 ns link period
    task automatic half;
        repeat (4) @(posedge mclk_i);
        #1;
    endtask

    task automatic set_mode(input bit m);
        mode3 = m;
        sck_o = m;
        half();
    endtask

    task automatic frame(input int n, input int ext, input int hat, input bit ab);
        cs_n_o = 1'b0;
        for (int i = 0; i < n * 8 + ext; i++) begin
            sck_o = 1'b0;
            if (i == hat) begin
                half();
                hold_n_o = 1'b0;
                half();
                sck_o = 1'b1;
                half();
                sck_o = 1'b0;
                half();
                if (ab) begin
                    cs_n_o = 1'b1;
                    half();
                    hold_n_o = 1'b1;
                    half();
                    return;
                end
                hold_n_o = 1'b1;
            end
            si_o = (i < n * 8) ? tx[i / 8][7 - i % 8] : 1'b0;
            half();
            sck_o = 1'b1;
            rx[i / 8][7 - i % 8] = so_oe_i ? so_i : 1'bz;
            half();
        end
        sck_o = mode3;
        half();
        cs_n_o = 1'b1;
        si_o = ~si_o;
        half();
    endtask
endmodule
`default_nettype wire

//--- verification/serial_flash_protect_hold_tb.sv
`default_nettype none
module serial_flash_protect_hold_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic       m3;
        logic       wp;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] st;
    } row_t;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wp_n_i = 1'b1;
    wire  sck, cs_n, si, hold_n, so, so_oe, active, sleep, busy;
    int   fails = 0;
    int   tests_run = 0;
    row_t rows [13] = '{
        '{1'b0, 1'b1, 8'h06, 8'h00, 8'h02},
        '{1'b1, 1'b1, 8'h04, 8'h00, 8'h00},
        '{1'b0, 1'b1, 8'h01, 8'h1c, 8'h00},
        '{1'b1, 1'b1, 8'h06, 8'h00, 8'h02},
        '{1'b0, 1'b1, 8'h01, 8'h1c, 8'h1c},
        '{1'b0, 1'b1, 8'h06, 8'h00, 8'h1e},
        '{1'b0, 1'b1, 8'hc7, 8'h00, 8'h1e},
        '{1'b1, 1'b1, 8'h01, 8'h00, 8'h00},
        '{1'b0, 1'b1, 8'h06, 8'h00, 8'h02},
        '{1'b0, 1'b1, 8'h01, 8'h9c, 8'h9c},
        '{1'b0, 1'b0, 8'h06, 8'h00, 8'h9e},
        '{1'b1, 1'b0, 8'h01, 8'h00, 8'h9e},
        '{1'b0, 1'b1, 8'h01, 8'h00, 8'h00}
    };

    always #5 mclk_i = ~mclk_i;

    serial_flash_protect_hold #(.ADDR_W(12), .SECT_W(8)) serial_flash_protect_hold_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe),
        .active_o(active), .deep_sleep_o(sleep), .busy_o(busy));
    sfp_host_model sfp_host_model_i (
        .mclk_i(mclk_i), .so_i(so), .so_oe_i(so_oe), .sck_o(sck), .cs_n_o(cs_n),
        .si_o(si), .hold_n_o(hold_n));

    task automatic report_and_stop;
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] q [$], input int ext = 0, input int hat = -1,
                        input bit ab = 1'b0);
        foreach (q[k]) sfp_host_model_i.tx[k] = q[k];
        sfp_host_model_i.frame(q.size(), ext, hat, ab);
    endtask

    task automatic idle;
        repeat (10) @(posedge mclk_i);
        for (int k = 0; k < 6000 && busy !== 1'b0; k++) @(posedge mclk_i);
        #1;
    endtask

    task automatic rd_status(input logic [7:0] exp);
        send({8'h05, 8'h00, 8'h00});
        chk(sfp_host_model_i.rx[1], exp);
        chk(sfp_host_model_i.rx[2], exp);
    endtask

    initial begin
        repeat (2) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (6) @(posedge mclk_i);
        #1;
        chk({4'h0, so_oe, active, sleep, busy}, 8'h00);
        rd_status(8'h00);
        foreach (rows[r]) begin
            sfp_host_model_i.set_mode(rows[r].m3);
            wp_n_i = rows[r].wp;
            if (rows[r].b0 == 8'h01) begin
                send({rows[r].b0, rows[r].b1});
            end else begin
                send({rows[r].b0});
            end
            idle();
            rd_status(rows[r].st);
        end
        send({8'h06});
        send({8'hd8, 8'h00, 8'h01, 8'h00});
        send({8'h05, 8'h00});
        chk({7'h00, sfp_host_model_i.rx[1][0]}, 8'h01);
        chk({7'h00, busy}, 8'h01);
        chk({7'h00, active}, 8'h01);
        idle();
        send({8'h06});
        send({8'h02, 8'h00, 8'h01, 8'h00, 8'ha5, 8'h3c});
        idle();
        send({8'h06});
        send({8'h02, 8'h00, 8'h01, 8'h00, 8'hf0, 8'hff});
        idle();
        rd_status(8'h00);
        send({8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
        chk(sfp_host_model_i.rx[4], 8'ha0);
        chk(sfp_host_model_i.rx[5], 8'h3c);
        chk(sfp_host_model_i.rx[6], 8'hff);
        send({8'h06});
        send({8'hd8, 8'h00, 8'h02, 8'h00}, 1);
        idle();
        rd_status(8'h02);
        send({8'h04});
        send({8'h06}, 0, 3);
        rd_status(8'h02);
        send({8'h04, 8'h00}, 0, 8, 1'b1);
        rd_status(8'h02);
        send({8'hd8, 8'h00, 8'h03, 8'h00});
        send({8'h05, 8'h00}, 0, 4);
        idle();
        send({8'h03, 8'h00, 8'h03, 8'h00, 8'h00});
        chk(sfp_host_model_i.rx[4], 8'hff);
        send({8'h06});
        send({8'hb9});
        idle();
        chk({7'h00, sleep}, 8'h01);
        send({8'hd8, 8'h00, 8'h04, 8'h00});
        repeat (10) @(posedge mclk_i);
        #1;
        chk({7'h00, busy}, 8'h00);
        send({8'hab});
        idle();
        chk({7'h00, sleep}, 8'h00);
        send({8'h06});
        send({8'hc7});
        idle();
        send({8'h03, 8'h00, 8'h01, 8'h00, 8'h00});
        chk(sfp_host_model_i.rx[4], 8'hff);
        report_and_stop();
    end

    initial begin
        repeat (60000) @(posedge mclk_i);
        fails++;
        report_and_stop();
    end
endmodule

bind serial_flash_protect_hold sfp_check_sva sfp_check_sva_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .active_o(active_o), .deep_sleep_o(deep_sleep_o), .busy_o(busy_o));
`default_nettype wire
